// ### mam_regs.svh
`ifndef MAM_REGS_SVH
`define MAM_REGS_SVH

// ==========================================================================
// Widths and positions.
`define MAM_ADDR_W       22
`define MAM_INT_ADDR_W   32
`define MAM_SD_ADDR_W    13
`define MAM_BANK_HI_BIT  21
`define MAM_BANK_LO_BIT  20
`define MAM_COL_MIN      8
`define MAM_COL_MAX      11
`define MAM_DATA_W       32

// ==========================================================================
// Reset values.
`define MAM_ADDR_RST     22'h000000
`define MAM_CS_N_RST     2'h3

`endif

// ### mam_pkg.sv
`include "mam_regs.svh"

package mam_pkg;

  // ========================================================================
  // Cycle kinds and widths.
  typedef enum logic [1:0] {MAM_CYC_IDLE, MAM_CYC_SDRAM, MAM_CYC_STATIC, MAM_CYC_IO} mam_cyc_t;
  typedef enum logic [1:0] {MAM_W8, MAM_W16, MAM_W32} mam_width_t;
  typedef enum logic [1:0] {MAM_PH_ROW, MAM_PH_COL, MAM_PH_NONE} mam_phase_t;

  // ========================================================================
  // Access request.
  typedef struct packed {
    mam_cyc_t                    cyc;
    mam_width_t                  width;
    mam_phase_t                  phase;
    logic                        sd_bank;
    logic [`MAM_INT_ADDR_W-1:0]  addr;
  } mam_req_t;

  // ========================================================================
  // Pin outputs.
  typedef struct packed {
    logic [`MAM_ADDR_W-1:0]  addr;
    logic [1:0]              sd_cs_n;
  } mam_pins_t;

endpackage : mam_pkg

// ### mam_sync.sv
`timescale 1ns/100ps

// ==========================================================================
// Two-stage synchroniser with edge detection on the second stage.
module mam_sync
  import mam_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Asynchronous level
  input  wire logic async_in,
  // Synchronised level and rising edge
  output logic      level_out,
  output logic      rise_out
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      // Reset high so that a pin already high gives no false edge.
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~last_q;

endmodule : mam_sync

// ### mam_memory_address_mux.sv
`timescale 1ns/100ps
`include "mam_regs.svh"

// Operation
// - Drive one shared 22-bit address bus.
// - SDRAM cycles emit row and column addresses.
// - Column bits programmable 8 to 11.
// - SDRAM address only on lines 12..0.
// - SDRAM bank bits on lines 21, 20.
// - Asynchronous cycles drive address bits 21, 20.
// - I/O cycles present byte address.
// - SDRAM and static addresses aligned by width.
// - System clock driven out for SDRAM.
// - SDRAM timing taken from clock input pin.
// - Data bus 32 bits, also 8 and 16.
// - Two SDRAM banks, active-low chip selects.
module mam_memory_address_mux
  import mam_pkg::*;
#(
  parameter int ADDR_W = `MAM_ADDR_W,
  parameter int DATA_W = `MAM_DATA_W
)
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  // Access request from the memory controller
  input  wire mam_req_t          req_in,
  input  wire logic [1:0]        col_bits_sel_in,
  // SDRAM clock pin and its rising edges
  input  wire logic              sdram_clock_in,
  output logic                   sdram_clk_rise_out,
  // System clock out
  output logic                   system_clock_out,
  // Address and chip selects
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   addr_hi_or_bank_sel_1,
  output logic                   addr_hi_or_bank_sel_0,
  output logic [1:0]             sdram_chip_select_n,
  // Data bus
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_en_in,
  output logic [DATA_W-1:0]      data_out,
  output logic [DATA_W/8-1:0]    data_oe_out,
  output logic [DATA_W-1:0]      rd_data_out
);

  // ========================================================================
  // Width decode used for both address and data lanes.
  function automatic logic [1:0] width_shift(input mam_width_t w);
    unique case (w)
      MAM_W8:  width_shift = 2'h0;
      MAM_W16: width_shift = 2'h1;
      MAM_W32: width_shift = 2'h2;
      default: width_shift = 2'h2;
    endcase
  endfunction : width_shift

  function automatic logic [DATA_W/8-1:0] lane_mask(input mam_width_t w);
    unique case (w)
      MAM_W8:  lane_mask = 4'h1;
      MAM_W16: lane_mask = 4'h3;
      MAM_W32: lane_mask = 4'hf;
      default: lane_mask = 4'hf;
    endcase
  endfunction : lane_mask

  // ========================================================================
  // Clocking.
  logic sd_level;

  mam_sync u_sd_sync
  (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .async_in  (sdram_clock_in),
    .level_out (sd_level),
    .rise_out  (sdram_clk_rise_out)
  );

  logic sysclk_q;
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sysclk_q <= 1'b0;
    else
      sysclk_q <= ~sysclk_q;
  end
  assign system_clock_out = sysclk_q;

  // ========================================================================
  // Address formation.
  logic [`MAM_INT_ADDR_W-1:0] word_addr;
  logic [3:0]                 col_n;
  logic [`MAM_INT_ADDR_W-1:0] row_val;
  logic [`MAM_INT_ADDR_W-1:0] col_mask;
  logic [`MAM_INT_ADDR_W-1:0] col_val;
  logic [ADDR_W-1:0]          addr_d;
  logic [ADDR_W-1:0]          addr_q;
  logic [1:0]                 bank_hit;
  logic [1:0]                 cs_n_d;
  logic [1:0]                 cs_n_q;

  assign word_addr = req_in.addr >> width_shift(req_in.width);
  assign col_n    = 4'(`MAM_COL_MIN) + {2'h0, col_bits_sel_in};
  assign row_val  = word_addr >> col_n;
  assign col_mask = (32'h1 << col_n) - 32'h1;
  assign col_val  = word_addr & col_mask;

  always_comb
  begin
    addr_d = addr_q;
    unique case (req_in.cyc)
      MAM_CYC_IDLE:
        addr_d = addr_q;
      MAM_CYC_SDRAM:
      begin
        addr_d = '0;
        if (req_in.phase == MAM_PH_ROW)
          addr_d[`MAM_SD_ADDR_W-1:0] = row_val[`MAM_SD_ADDR_W-1:0];
        else
          addr_d[`MAM_SD_ADDR_W-1:0] = col_val[`MAM_SD_ADDR_W-1:0];
        addr_d[`MAM_BANK_HI_BIT:`MAM_BANK_LO_BIT] = row_val[`MAM_SD_ADDR_W+1:`MAM_SD_ADDR_W];
      end
      MAM_CYC_STATIC:
        addr_d = word_addr[ADDR_W-1:0];
      MAM_CYC_IO:
        addr_d = req_in.addr[ADDR_W-1:0];
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      addr_q <= `MAM_ADDR_RST;
    else
      addr_q <= addr_d;
  end

  assign addr_out              = addr_q;
  assign addr_hi_or_bank_sel_1 = addr_q[`MAM_BANK_HI_BIT];
  assign addr_hi_or_bank_sel_0 = addr_q[`MAM_BANK_LO_BIT];

  // ========================================================================
  // Chip selects.

  for (genvar bank = 0; bank < 2; bank++)
  begin : g_bank
    assign bank_hit[bank] = (req_in.cyc == MAM_CYC_SDRAM) && (req_in.sd_bank == 1'(bank));
  end
  assign cs_n_d = ~bank_hit;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cs_n_q <= `MAM_CS_N_RST;
    else
      cs_n_q <= cs_n_d;
  end

  assign sdram_chip_select_n = cs_n_q;

  // ========================================================================
  // Data bus lanes.
  logic [DATA_W/8-1:0] lane_en;
  logic [DATA_W-1:0]   dout_q;
  logic [DATA_W/8-1:0] oe_q;
  logic [DATA_W-1:0]   din_q;

  assign lane_en = wr_en_in ? lane_mask(req_in.width) : '0;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      dout_q <= '0;
    else
      dout_q <= wr_data_in;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      oe_q <= '0;
    else
      oe_q <= lane_en;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      din_q <= '0;
    else
      din_q <= data_in;
  end

  assign data_out    = dout_q;
  assign data_oe_out = oe_q;
  assign rd_data_out = din_q;

  logic unused_level;
  assign unused_level = sd_level;

endmodule : mam_memory_address_mux

// ### mam_memory_address_mux_assertions.sv
`timescale 1ns/100ps
// ====================
// Port checks.
module mam_mux_checker
  import mam_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire mam_req_t    req_in,
  input wire logic        sdram_clock_in,
  input wire logic        sdram_clk_rise_out,
  input wire logic        system_clock_out,
  input wire logic [21:0] addr_out,
  input wire logic        addr_hi_or_bank_sel_1,
  input wire logic        addr_hi_or_bank_sel_0,
  input wire logic [1:0]  sdram_chip_select_n,
  input wire logic        wr_en_in,
  input wire logic [3:0]  data_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  AST_HI: assert property ({addr_hi_or_bank_sel_1, addr_hi_or_bank_sel_0} == addr_out[21:20])
    else $error("hi lines");
  AST_HI_ST: assert property (req_in.cyc == MAM_CYC_STATIC && req_in.width == MAM_W8 |=>
    {addr_hi_or_bank_sel_1, addr_hi_or_bank_sel_0} == $past(req_in.addr[21:20]))
    else $error("static hi lines");
  AST_CS_SD: assert property (req_in.cyc == MAM_CYC_SDRAM |=>
    sdram_chip_select_n == {!$past(req_in.sd_bank), $past(req_in.sd_bank)})
    else $error("sdram select");
  AST_CS_OFF: assert property (req_in.cyc inside {MAM_CYC_STATIC, MAM_CYC_IO} |=> sdram_chip_select_n == 2'h3)
    else $error("select off");
  AST_IO: assert property (req_in.cyc == MAM_CYC_IO |=> addr_out == $past(req_in.addr[21:0]))
    else $error("io addr");
  AST_SD_MID: assert property (req_in.cyc == MAM_CYC_SDRAM |=> addr_out[19:13] == 7'h0)
    else $error("sdram mid lines");
  AST_SYSCLK: assert property (nrst_in |=> system_clock_out != $past(system_clock_out))
    else $error("clock out");
  AST_LINK: assert property ($rose(sdram_clock_in) |-> ##[1:3] sdram_clk_rise_out)
    else $error("link edge");
  AST_OE: assert property (!wr_en_in |=> data_oe_out == 4'h0)
    else $error("bus enable");
endmodule : mam_mux_checker

bind mam_memory_address_mux mam_mux_checker i_mam_mux_checker (.clk_in, .nrst_in, .req_in, .sdram_clock_in,
  .sdram_clk_rise_out, .system_clock_out, .addr_out, .addr_hi_or_bank_sel_1, .addr_hi_or_bank_sel_0,
  .sdram_chip_select_n, .wr_en_in, .data_oe_out);

// ### mam_mem_model.sv
`timescale 1ns/100ps
// ====================
// Memory that answers with the address seen while no lane is enabled, and with its last word inverted while one is.
module mam_mem_model
  import mam_pkg::*;
(
  input  wire logic [0:0]  clk_in,
  input  wire logic [21:0] addr_in,
  input  wire logic [3:0]  oe_in,
  output logic      [31:0] data_out
);
  initial data_out = 32'h0;
  always @(posedge clk_in)
    data_out <= (oe_in != 4'h0) ? ~data_out : {10'h0, addr_in};
endmodule : mam_mem_model

// ### test_memory_address_mux.sv
`timescale 1ns/100ps
// ====================
// Testbench.
module test_memory_address_mux
  import mam_pkg::*;
;
  logic        clk_in = 1'b0, nrst_in = 1'b0, sdram_clock_in = 1'b0, rise, sclk, hi1, hi0, wr_en_in = 1'b0;
  mam_req_t    req_in = '0;
  logic [1:0]  col = 2'h0, cs_n;
  logic [21:0] addr_out;
  logic [31:0] data_in, wr_data_in = 32'h0, data_out, rd_data_out, wd, row;
  logic [3:0]  oe;
  int          err_total = 0, compares = 0;
  always #2.5 clk_in = ~clk_in;
  always #40 sdram_clock_in = ~sdram_clock_in;
  mam_memory_address_mux i_mam_memory_address_mux (.clk_in, .nrst_in, .req_in, .col_bits_sel_in(col),
    .sdram_clock_in, .sdram_clk_rise_out(rise), .system_clock_out(sclk), .addr_out, .addr_hi_or_bank_sel_1(hi1),
    .addr_hi_or_bank_sel_0(hi0), .sdram_chip_select_n(cs_n), .data_in, .wr_data_in, .wr_en_in, .data_out,
    .data_oe_out(oe), .rd_data_out);
  mam_mem_model i_mam_mem_model (.clk_in, .addr_in(addr_out), .oe_in(oe), .data_out(data_in));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic go(input mam_req_t r, input logic [1:0] c);
    @(posedge clk_in);
    req_in <= r;
    col <= c;
    @(posedge clk_in);
    req_in.cyc <= MAM_CYC_IDLE;
    #1;
  endtask : go
  task automatic t_static;
    mam_width_t w;
    w = MAM_W8;
    repeat (3)
    begin
      go('{MAM_CYC_STATIC, w, MAM_PH_NONE, 1'b1, 32'hf0ea_5a57}, 2'h3);
      chk("static addr", 32'(22'(32'hf0ea_5a57 >> w)), 32'(addr_out));
      chk("static cs", 32'h3, 32'(cs_n));
      chk("static hi", 32'(22'(32'hf0ea_5a57 >> w) >> 20), 32'({hi1, hi0}));
      w = w.next();
    end
    go('{MAM_CYC_IO, MAM_W32, MAM_PH_NONE, 1'b0, 32'hf0ea_5a57}, 2'h0);
    chk("io addr", 32'h2a_5a57, 32'(addr_out));
    $display("static and io done");
  endtask : t_static
  task automatic t_sdram;
    wd = 32'h0ba5_c3e4 >> 2;
    for (int c = 0; c < 4; c++)
    begin
      row = wd >> (8 + c);
      go('{MAM_CYC_SDRAM, MAM_W32, MAM_PH_ROW, c[0], 32'h0ba5_c3e4}, 2'(c));
      chk("row", {10'h0, row[14:13], 7'h0, row[12:0]}, 32'(addr_out));
      chk("bank cs", c[0] ? 32'h1 : 32'h2, 32'(cs_n));
      chk("bank lines", 32'(row[14:13]), 32'({hi1, hi0}));
      go('{MAM_CYC_SDRAM, MAM_W32, MAM_PH_COL, c[0], 32'h0ba5_c3e4}, 2'(c));
      chk("col", {10'h0, row[14:13], 7'h0, 13'(wd & ((32'h1 << (8 + c)) - 1))}, 32'(addr_out));
    end
    $display("sdram done");
  endtask : t_sdram
  task automatic t_wr;
    mam_width_t w;
    w = MAM_W8;
    @(posedge clk_in);
    wr_en_in <= 1'b1;
    wr_data_in <= 32'h5a5a_0ff0;
    repeat (3)
    begin
      go('{MAM_CYC_STATIC, w, MAM_PH_NONE, 1'b0, 32'h1234}, 2'h0);
      chk("oe", (32'h1 << (32'h1 << w)) - 32'h1, 32'(oe));
      w = w.next();
    end
    chk("wdata", 32'h5a5a_0ff0, data_out);
    @(posedge clk_in);
    wr_en_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    chk("oe off", 32'h0, 32'(oe));
    chk("rdata", 32'h48d, rd_data_out);
    $display("write and read done");
  endtask : t_wr
  task automatic t_rst;
    int n;
    n = 0;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk("rst addr", 32'h0, 32'(addr_out));
    chk("rst cs", 32'h3, 32'(cs_n));
    chk("rst oe", 32'h0, 32'(oe));
    chk("rst wdata", 32'h0, data_out);
    chk("rst clock", 32'h0, 32'(sclk));
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (sdram_clock_in !== 1'b1 && n < 20);
    chk("pin wait", 32'h1, 32'(sdram_clock_in));
    nrst_in <= 1'b1;
    n = 0;
    repeat (3)
    begin
      @(posedge clk_in);
      #1;
      n += int'(rise);
    end
    chk("no false edge", 32'h0, 32'(n));
    $display("reset done");
  endtask : t_rst
  task automatic t_clk;
    int nr, ns;
    nr = 0;
    ns = 0;
    repeat (160)
    begin
      @(posedge clk_in);
      #1;
      nr += int'(rise);
      ns += int'(sclk);
    end
    chk("link rises", 32'd10, 32'(nr));
    chk("clock highs", 32'd80, 32'(ns));
    $display("clocks done");
  endtask : t_clk
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_static;
    t_sdram;
    t_wr;
    t_rst;
    t_clk;
    finish_test;
  end
endmodule : test_memory_address_mux
